// ===== line_debounce.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Glitch filter: output follows input after a stable run
// ==========================================================
module line_debounce (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       line_i,
    input  wire logic [1:0] sel_i,
    output logic            line_o
);
    logic [2:0] run_ff;
    logic       filt_ff;
    logic [2:0] need;

    // Code 00 none, 01 two clocks, 1x four clocks
    assign need   = sel_i[1] ? serial_iface_pkg::DEB_FOUR :
                    sel_i[0] ? serial_iface_pkg::DEB_TWO : 3'h0;
    assign line_o = (need == 3'h0) ? line_i : filt_ff;

    // Restart the count whenever the input agrees with the output
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_ff  <= 3'h0;
            filt_ff <= 1'b1;
        end else if (line_i == filt_ff) begin
            run_ff <= 3'h0;
        end else if (run_ff + 3'h1 >= need) begin
            filt_ff <= line_i;
            run_ff  <= 3'h0;
        end else begin
            run_ff <= run_ff + 3'h1;
        end
    end
endmodule : line_debounce

`default_nettype wire

// ===== serial_iface_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Port checker for the serial interface
module serial_iface_asserts (
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic [1:0] pullup_ctrl_i,
    input wire logic [1:0] pullup_en_o,
    input wire logic       sck_o,
    input wire logic       sck_oe_n_o,
    input wire logic       sdi_oe_n_o,
    input wire logic       sdo_o,
    input wire logic       sdo_oe_n_o,
    input wire logic       sda_oe_n_o,
    input wire logic       scl_oe_n_o,
    input wire logic       pins_owned_o
);
    logic [2:0] mode_ff;
    logic       pol_ff;
    logic [9:0] quiet_ff;
    wire        mst = pins_owned_o && mode_ff <= 3'h2;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Mirror of mode and polarity; index 3 is the address in I2C mode
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_ff <= 3'h7;
            pol_ff  <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == 3'h0) begin
            mode_ff <= reg_wdata_i[7:5];
        end else if (reg_wr_i && reg_addr_i == 3'h3 && mode_ff != 3'h6) begin
            pol_ff  <= reg_wdata_i[5];
        end
    end
    // Cycles since a write; slowest divided transfer stays under 700
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) quiet_ff <= 10'h3ff;
        else if (reg_wr_i) quiet_ff <= 10'h000;
        else if (quiet_ff != 10'h3ff) quiet_ff <= quiet_ff + 10'h001;
    end
    a_sdi_floats: assert property (sdi_oe_n_o)
        else $error("data input pin driven");
    a_enable_sdo_hi: assert property ($rose(pins_owned_o) |-> sdo_o)
        else $error("data output not high when enabled");
    a_idle_sck_lvl: assert property (
        mst && quiet_ff > 10'h2bc |-> !sck_oe_n_o && sck_o == !pol_ff)
        else $error("clock idle level wrong");
    a_slave_sck_in: assert property (
        mode_ff == 3'h5 && $past(mode_ff) == 3'h5 |-> sck_oe_n_o)
        else $error("slave drives clock pin");
    a_off_released: assert property (
        !pins_owned_o |-> sck_oe_n_o && sdo_oe_n_o)
        else $error("pins driven while disabled");
    a_sck_after_wr: assert property (
        mst && $changed(sck_o) |-> quiet_ff < 10'h2bc)
        else $error("clock moved without a data write");
    a_i2c_released: assert property (sda_oe_n_o && scl_oe_n_o)
        else $error("open-drain line pulled by block");
    a_pullup_copy: assert property (
        !$past(sys_rst_i) |-> pullup_en_o == $past(pullup_ctrl_i))
        else $error("pull-up enable not following request");
endmodule : serial_iface_asserts
`default_nettype wire

// ===== serial_iface_pkg.sv
package serial_iface_pkg;

    // ==========================================================
    // Register offsets (plain port, byte-wide registers)
    // ==========================================================
    localparam logic [2:0] OFF_MODE_CTRL0  = 3'h0;
    localparam logic [2:0] OFF_BUS_CTRL1   = 3'h1;
    localparam logic [2:0] OFF_SHIFT_DATA  = 3'h2;
    localparam logic [2:0] OFF_SPI_CTRL2   = 3'h3;
    localparam logic [2:0] OFF_TIMEOUT     = 3'h4;

    // ==========================================================
    // Mode control 0 fields
    // ==========================================================
    localparam int MODE_LSB     = 5;
    localparam int DEB_LSB      = 2;
    localparam int EN_BIT       = 1;
    localparam int ICF_BIT      = 0;
    localparam logic [7:0] MODE_CTRL0_RST = 8'he0;

    // Operating modes
    localparam logic [2:0] MODE_MST_DIV4  = 3'h0;
    localparam logic [2:0] MODE_MST_DIV16 = 3'h1;
    localparam logic [2:0] MODE_MST_DIV64 = 3'h2;
    localparam logic [2:0] MODE_MST_SUB   = 3'h3;
    localparam logic [2:0] MODE_MST_TMR   = 3'h4;
    localparam logic [2:0] MODE_SPI_SLV   = 3'h5;
    localparam logic [2:0] MODE_I2C_SLV   = 3'h6;

    // ==========================================================
    // SPI control 2 fields
    // ==========================================================
    localparam int POL_BIT      = 5;
    localparam int EDGE_BIT     = 4;
    localparam int ORDER_BIT    = 3;
    localparam int SELECT_PIN_ENABLE_BIT     = 2;
    localparam int WRITE_COLLISION_FLAG_BIT     = 1;
    localparam int TRF_BIT      = 0;
    localparam logic [7:0] SPI_CTRL2_RST = 8'h00;

    // Bus status control 1 and others
    localparam logic [7:0] BUS_CTRL1_RST = 8'h81;
    localparam logic [7:0] BUS_CTRL1_WMASK = 8'h1a;
    localparam logic [7:0] TIMEOUT_RST   = 8'h00;
    localparam logic [7:0] SHIFT_RST     = 8'h00;

    // ==========================================================
    // Timing counts (half periods of generated clock and debounce runs, in clk_i; bits per transfer)
    // ==========================================================
    localparam logic [7:0] HALF_DIV4  = 8'h02;
    localparam logic [7:0] HALF_DIV16 = 8'h08;
    localparam logic [7:0] HALF_DIV64 = 8'h20;
    localparam logic [3:0] BITS_PER_XFER = 4'h8;
    localparam logic [2:0] DEB_TWO  = 3'h2;
    localparam logic [2:0] DEB_FOUR = 3'h4;

endpackage : serial_iface_pkg

// ===== serial_iface_spi_i2c_slave.sv
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module serial_iface_spi_i2c_slave (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Register port
    input  wire logic [2:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // Alternate clock sources for master modes
    input  wire logic       sub_clk_i,
    input  wire logic       tmr_clk_i,
    // Pull-up enables for I2C lines
    input  wire logic [1:0] pullup_ctrl_i,
    output logic      [1:0] pullup_en_o,
    // SPI pins
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe_n_o,
    input  wire logic       slave_select_n_i,
    input  wire logic       sdi_i,
    output logic            sdi_oe_n_o,
    output logic            sdo_o,
    output logic            sdo_oe_n_o,
    // I2C pins (shared with SPI clock and data-in)
    input  wire logic       sda_i,
    output logic            sda_oe_n_o,
    output logic            scl_oe_n_o,
    // Pin ownership
    output logic            pins_owned_o
);

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0] mode_control_0_ff;
    logic [7:0] bus_status_control_1_ff;
    logic [7:0] shift_data_ff;
    logic [7:0] spi_control_2_ff;
    logic [7:0] slave_address_ff;
    logic [7:0] timeout_control_ff;
    logic [7:0] shift_buffer_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] div_cnt_ff;
    logic       gen_clk_ff;
    logic       sdo_ff;
    logic [7:0] rdata_ff;
    logic [1:0] sck_sync_ff;
    logic [1:0] ss_sync_ff;
    logic [1:0] sdi_sync_ff;
    logic [1:0] sub_sync_ff;
    logic [1:0] tmr_sync_ff;
    logic       sck_prev_ff;
    logic       ss_prev_ff;
    logic       src_prev_ff;
    logic       sck_o_ff;
    logic       sck_oe_n_ff;
    logic       sdi_oe_n_ff;
    logic       sdo_oe_n_ff;
    logic       sda_oe_n_ff;
    logic       scl_oe_n_ff;
    logic [1:0] pullup_ff;
    logic       owned_ff;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE  = 3'b100
    } xfer_e;
    xfer_e state_ff;
    xfer_e nxt_state;

    // ==========================================================
    // Field decode
    // ==========================================================
    wire [2:0] operating_mode_sel  = mode_control_0_ff[7:5];
    wire [1:0] debounce_select     = mode_control_0_ff[3:2];
    wire       iface_enable        =
        mode_control_0_ff[serial_iface_pkg::EN_BIT];
    wire       clock_idle_polarity =
        spi_control_2_ff[serial_iface_pkg::POL_BIT];
    wire       clock_edge_sel      =
        spi_control_2_ff[serial_iface_pkg::EDGE_BIT];
    wire       bit_order_select    =
        spi_control_2_ff[serial_iface_pkg::ORDER_BIT];
    wire       select_pin_enable   =
        spi_control_2_ff[serial_iface_pkg::SELECT_PIN_ENABLE_BIT];

    // Mode classes
    wire is_master = (operating_mode_sel <=
                      serial_iface_pkg::MODE_MST_TMR);
    wire is_slave  = (operating_mode_sel ==
                      serial_iface_pkg::MODE_SPI_SLV);
    wire is_i2c    = (operating_mode_sel ==
                      serial_iface_pkg::MODE_I2C_SLV);
    wire spi_on    = iface_enable && (is_master || is_slave);
    wire i2c_on    = iface_enable && is_i2c;

    // ==========================================================
    // Input synchronisers (second stage only is read)
    // ==========================================================
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sck_sync_ff <= 2'b11; // Idle high, so no false edge
            ss_sync_ff  <= 2'b11;
            sdi_sync_ff <= 2'b00;
            sub_sync_ff <= 2'b00;
            tmr_sync_ff <= 2'b00;
        end else begin
            sck_sync_ff <= {sck_sync_ff[0], sck_i};
            ss_sync_ff  <= {ss_sync_ff[0], slave_select_n_i};
            sdi_sync_ff <= {sdi_sync_ff[0], sdi_i};
            sub_sync_ff <= {sub_sync_ff[0], sub_clk_i};
            tmr_sync_ff <= {tmr_sync_ff[0], tmr_clk_i};
        end
    end

    // I2C clock glitch filter on the synchronised line
    logic scl_clean;
    line_debounce u_scl_deb (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .line_i    (sck_sync_ff[1]),
        .sel_i     (debounce_select),
        .line_o    (scl_clean)
    );

    // ==========================================================
    // Master clock source: divider or external tick source
    // ==========================================================
    wire [7:0] half_cnt =
        (operating_mode_sel == serial_iface_pkg::MODE_MST_DIV16) ?
            serial_iface_pkg::HALF_DIV16 :
        (operating_mode_sel == serial_iface_pkg::MODE_MST_DIV64) ?
            serial_iface_pkg::HALF_DIV64 : serial_iface_pkg::HALF_DIV4;
    wire ext_src  = (operating_mode_sel == serial_iface_pkg::MODE_MST_SUB)
                    ? sub_sync_ff[1] : tmr_sync_ff[1];
    wire use_ext  = (operating_mode_sel == serial_iface_pkg::MODE_MST_SUB)
                 || (operating_mode_sel == serial_iface_pkg::MODE_MST_TMR);
    // Tick marks each half period of the generated clock
    wire div_tick = (div_cnt_ff + 8'h01 >= half_cnt);
    wire ext_tick = ext_src && !src_prev_ff;
    wire half_tick = use_ext ? ext_tick : div_tick;

    // ==========================================================
    // Shift edges for both roles
    // ==========================================================
    // Leading edge leaves idle level; capture edge set by edge select
    wire gen_lead  = half_tick && !gen_clk_ff;
    wire gen_trail = half_tick &&  gen_clk_ff;
    wire sck_s     = sck_sync_ff[1];
    wire ext_rise  = sck_s && !sck_prev_ff;
    wire ext_fall  = !sck_s && sck_prev_ff;
    wire ext_lead  = clock_idle_polarity ? ext_rise : ext_fall;
    wire ext_trail = clock_idle_polarity ? ext_fall : ext_rise;
    // Slave only shifts while selected, or always with select disabled
    wire slv_sel   = !select_pin_enable || !ss_sync_ff[1];
    wire lead_e    = is_master ? gen_lead  : (ext_lead  && slv_sel);
    wire trail_e   = is_master ? gen_trail : (ext_trail && slv_sel);
    // Edge select swaps capture and launch edges
    wire cap_e     = clock_edge_sel ? lead_e : trail_e;
    wire launch_e  = clock_edge_sel ? trail_e : lead_e;

    wire busy      = (state_ff == ST_SHIFT);
    wire shift_wr  = reg_wr_i &&
                     (reg_addr_i == serial_iface_pkg::OFF_SHIFT_DATA);
    wire collide   = shift_wr && busy;
    wire load      = shift_wr && !busy && spi_on;
    wire last_cap  = busy && cap_e &&
                     (bit_cnt_ff == serial_iface_pkg::BITS_PER_XFER - 4'h1);
    // Abort only on a select release, not while waiting for select
    wire ss_rise   = ss_sync_ff[1] && !ss_prev_ff;
    wire slv_abort = busy && is_slave && select_pin_enable && ss_rise;
    wire out_bit   = bit_order_select ? shift_buffer_ff[7]
                                      : shift_buffer_ff[0];

    // ==========================================================
    // Transfer sequencer
    // ==========================================================
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:  if (load) nxt_state = ST_SHIFT;
            ST_SHIFT: if (!spi_on || slv_abort) nxt_state = ST_IDLE;
                      else if (last_cap) nxt_state = ST_DONE;
            ST_DONE:  nxt_state = ST_IDLE;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    // Shifting datapath; capture accumulates in the buffer only
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff        <= ST_IDLE;
            shift_buffer_ff <= serial_iface_pkg::SHIFT_RST;
            bit_cnt_ff      <= 4'h0;
            sdo_ff          <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            if (load) begin
                shift_buffer_ff <= reg_wdata_i;
                bit_cnt_ff      <= 4'h0;
                sdo_ff          <= bit_order_select ? reg_wdata_i[7]
                                                    : reg_wdata_i[0];
            end else if (busy && cap_e) begin
                shift_buffer_ff <= bit_order_select
                    ? {shift_buffer_ff[6:0], sdi_sync_ff[1]}
                    : {sdi_sync_ff[1], shift_buffer_ff[7:1]};
                bit_cnt_ff      <= bit_cnt_ff + 4'h1;
            end else if (busy && launch_e && bit_cnt_ff != 4'h0) begin
                sdo_ff <= out_bit;
            end else if (!busy) begin
                sdo_ff <= 1'b1;
            end
        end
    end

    // Generated clock; runs only while a master transfer is active
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_cnt_ff  <= 8'h00;
            gen_clk_ff  <= 1'b0;
            src_prev_ff <= 1'b0;
            sck_prev_ff <= 1'b1;
            ss_prev_ff  <= 1'b1;
        end else begin
            src_prev_ff <= ext_src;
            sck_prev_ff <= sck_s;
            ss_prev_ff  <= ss_sync_ff[1];
            if (!(busy && is_master)) begin
                div_cnt_ff <= 8'h00;
                gen_clk_ff <= 1'b0;
            end else if (half_tick) begin
                div_cnt_ff <= 8'h00;
                gen_clk_ff <= !gen_clk_ff;
            end else begin
                div_cnt_ff <= div_cnt_ff + 8'h01;
            end
        end
    end

    // ==========================================================
    // Register writes and hardware flags (set wins over clear)
    // ==========================================================
    wire wr_c0 = reg_wr_i && reg_addr_i == serial_iface_pkg::OFF_MODE_CTRL0;
    wire wr_c1 = reg_wr_i && reg_addr_i == serial_iface_pkg::OFF_BUS_CTRL1;
    wire wr_c2 = reg_wr_i && reg_addr_i == serial_iface_pkg::OFF_SPI_CTRL2;
    wire wr_to = reg_wr_i && reg_addr_i == serial_iface_pkg::OFF_TIMEOUT;
    wire done_set = (state_ff == ST_DONE);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_control_0_ff       <= serial_iface_pkg::MODE_CTRL0_RST;
            bus_status_control_1_ff <= serial_iface_pkg::BUS_CTRL1_RST;
            spi_control_2_ff        <= serial_iface_pkg::SPI_CTRL2_RST;
            slave_address_ff        <= serial_iface_pkg::SHIFT_RST;
            timeout_control_ff      <= serial_iface_pkg::TIMEOUT_RST;
            shift_data_ff           <= serial_iface_pkg::SHIFT_RST;
        end else begin
            if (wr_c0) begin
                mode_control_0_ff <= reg_wdata_i & 8'hef;
            end
            if (slv_abort) begin
                mode_control_0_ff[serial_iface_pkg::ICF_BIT] <= 1'b1;
            end
            if (wr_c1) begin
                bus_status_control_1_ff <=
                    (bus_status_control_1_ff &
                     ~serial_iface_pkg::BUS_CTRL1_WMASK) |
                    (reg_wdata_i & serial_iface_pkg::BUS_CTRL1_WMASK);
            end
            if (wr_to) begin
                timeout_control_ff <= reg_wdata_i;
            end
            // Address and SPI control share one location by mode
            if (wr_c2 && is_i2c) begin
                slave_address_ff <= reg_wdata_i;
            end else if (wr_c2) begin
                spi_control_2_ff <= reg_wdata_i;
            end
            if (collide) begin
                spi_control_2_ff[serial_iface_pkg::WRITE_COLLISION_FLAG_BIT] <= 1'b1;
            end
            if (done_set || slv_abort) begin
                spi_control_2_ff[serial_iface_pkg::TRF_BIT] <= 1'b1;
            end
            // Completed byte copied in; idle writes stage transmit data
            if (done_set) begin
                shift_data_ff <= shift_buffer_ff;
            end else if (shift_wr && !busy) begin
                shift_data_ff <= reg_wdata_i;
            end
        end
    end

    // ==========================================================
    // Read port: data one cycle after the strobe
    // ==========================================================
    wire [7:0] rd_mux =
        (reg_addr_i == serial_iface_pkg::OFF_MODE_CTRL0) ? mode_control_0_ff :
        (reg_addr_i == serial_iface_pkg::OFF_BUS_CTRL1) ?
            bus_status_control_1_ff :
        (reg_addr_i == serial_iface_pkg::OFF_SHIFT_DATA) ? shift_data_ff :
        (reg_addr_i == serial_iface_pkg::OFF_SPI_CTRL2) ?
            (is_i2c ? slave_address_ff : spi_control_2_ff) :
        (reg_addr_i == serial_iface_pkg::OFF_TIMEOUT) ? timeout_control_ff :
        8'h00;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
        end
    end

    // ==========================================================
    // Pin control, registered; enables are active low
    // ==========================================================
    wire idle_lvl = !clock_idle_polarity;
    wire gen_pin  = gen_clk_ff ? !idle_lvl : idle_lvl;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sck_o_ff    <= 1'b1;
            sck_oe_n_ff <= 1'b1;
            sdi_oe_n_ff <= 1'b1;
            sdo_oe_n_ff <= 1'b1;
            sda_oe_n_ff <= 1'b1;
            scl_oe_n_ff <= 1'b1;
            pullup_ff   <= 2'b00;
            owned_ff    <= 1'b0;
        end else begin
            owned_ff    <= iface_enable;
            sck_o_ff    <= gen_pin;
            sck_oe_n_ff <= !(spi_on && is_master);
            sdi_oe_n_ff <= 1'b1;
            sdo_oe_n_ff <= !(spi_on && select_pin_enable);
            // Slave never drives the clock or the data line; both stay released
            scl_oe_n_ff <= 1'b1;
            sda_oe_n_ff <= 1'b1;
            pullup_ff   <= pullup_ctrl_i;
        end
    end

    assign reg_rdata_o  = rdata_ff;
    assign sck_o        = sck_o_ff;
    assign sck_oe_n_o   = sck_oe_n_ff;
    assign sdi_oe_n_o   = sdi_oe_n_ff;
    assign sdo_o        = sdo_ff;
    assign sdo_oe_n_o   = sdo_oe_n_ff;
    assign sda_oe_n_o   = sda_oe_n_ff;
    assign scl_oe_n_o   = scl_oe_n_ff;
    assign pullup_en_o  = pullup_ff;
    assign pins_owned_o = owned_ff;

    // Unused I2C inputs and the fixed data-in enable held for the excluded protocol engine
    wire unused_ok = &{1'b0, sda_i, scl_clean, sdi_oe_n_ff};

endmodule : serial_iface_spi_i2c_slave

`default_nettype wire

// ===== spi_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// External SPI master: clock idles high, launch on fall, capture on rise
module spi_peer_model (
    output logic      sck_o,
    output logic      ss_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    initial begin
        sck_o  = 1'b1;
        ss_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Select first, then nbits MSB first; slow stretches every phase but the closing 200 ns hold
    task automatic xfer(input logic [7:0] tx, input int nbits,
                        input int slow, output logic [7:0] rx);
        rx     = 8'h00;
        ss_n_o = 1'b0;
        #(200 + slow);
        for (int i = 7; i > 7 - nbits; i--) begin
            sck_o  = 1'b0;
            mosi_o = tx[i];
            #(62.5 + slow);
            sck_o  = 1'b1;
            rx[i]  = miso_i;
            #(62.5 + slow);
        end
        #200;
        ss_n_o = 1'b1;
        mosi_o = ~mosi_o; // Released line must not show a stale bit
    endtask : xfer
endmodule : spi_peer_model
`default_nettype wire

// ===== tb_serial_iface_spi_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Bench: register port, loopback master, peer-driven slave
module tb_serial_iface_spi_i2c_slave;
    logic       clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [1:0] pull = 2'h0;
    logic       loop = 1'b0;
    logic [7:0] rdata;
    logic [1:0] pull_en;
    logic       sck, sck_oe_n, sdi_oe_n, sdo, sdo_oe_n, sda_oe_n, scl_oe_n;
    logic       owned;
    wire        p_sck, p_ss_n, p_mosi;
    int         miscompares = 0;
    int         n_checks = 0;
    int         cyc = 0;
    int         n_rise = 0;
    always #2.5 clk_i = ~clk_i; // 200 MHz, above any minimum
    always @(posedge sck) n_rise++;
    serial_iface_spi_i2c_slave uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .sub_clk_i(1'b0), .tmr_clk_i(1'b0),
        .pullup_ctrl_i(pull), .pullup_en_o(pull_en), .sck_i(p_sck),
        .sck_o(sck), .sck_oe_n_o(sck_oe_n), .slave_select_n_i(p_ss_n),
        .sdi_i(loop ? sdo : p_mosi), .sdi_oe_n_o(sdi_oe_n), .sdo_o(sdo),
        .sdo_oe_n_o(sdo_oe_n), .sda_i(1'b1), .sda_oe_n_o(sda_oe_n),
        .scl_oe_n_o(scl_oe_n), .pins_owned_o(owned));
    spi_peer_model peer (.sck_o(p_sck), .ss_n_o(p_ss_n), .mosi_o(p_mosi),
        .miso_i(sdo));
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr    <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_raw(input logic [2:0] a);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd   <= 1'b0;
        @(negedge clk_i);
    endtask : rd_raw
    task automatic rd_chk(input string nm, input logic [2:0] a,
                          input logic [7:0] exp);
        rd_raw(a);
        chk(nm, rdata, exp);
    endtask : rd_chk
    // Bounded poll of the done flag; polls themselves are not checks
    task automatic wait_done();
        for (int i = 0; i < 300 && rdata[0] !== 1'b1; i++) begin
            rd_raw(serial_iface_pkg::OFF_SPI_CTRL2);
        end
        chk("done", {7'h00, rdata[0]}, 8'h01);
    endtask : wait_done
    task automatic t_reset();
        rd_chk("ctrl0", 3'h0, serial_iface_pkg::MODE_CTRL0_RST);
        rd_chk("ctrl2", 3'h3, serial_iface_pkg::SPI_CTRL2_RST);
        rd_chk("tmo", 3'h4, serial_iface_pkg::TIMEOUT_RST);
        rd_chk("unmapped", 3'h7, 8'h00);
        wr_reg(3'h1, 8'hff);
        rd_chk("ctrl1", 3'h1, serial_iface_pkg::BUS_CTRL1_RST | 8'h1a);
        chk("off pins", {5'h00, sck_oe_n, sdo_oe_n, owned}, 8'h06);
    endtask : t_reset
    task automatic t_modes();
        for (int m = 0; m < 7; m++) begin
            wr_reg(3'h0, {m[2:0], 1'b0, m[1:0], 2'b00});
            rd_chk("mode", 3'h0, {m[2:0], 1'b0, m[1:0], 2'b00});
        end
        wr_reg(3'h0, {serial_iface_pkg::MODE_I2C_SLV, 5'h02});
        wr_reg(3'h3, 8'ha5);
        rd_chk("address", 3'h3, 8'ha5);
        pull <= 2'h2;
        repeat (3) @(negedge clk_i);
        chk("i2c", {4'h0, sda_oe_n, scl_oe_n, sdi_oe_n, owned}, 8'h0f);
        chk("pullup", {6'h00, pull_en}, 8'h02);
    endtask : t_modes
    // Loopback byte with a refused second write
    task automatic t_master();
        wr_reg(3'h0, {serial_iface_pkg::MODE_MST_DIV16, 5'h02});
        wr_reg(3'h3, 8'h0c);
        loop <= 1'b1;
        repeat (8) @(negedge clk_i);
        n_rise = 0;
        chk("idle", {3'h0, sck, sck_oe_n, sdi_oe_n, sdo, sdo_oe_n}, 8'h16);
        wr_reg(3'h2, 8'ha5);
        wr_reg(3'h2, 8'h3c);
        wait_done();
        rd_chk("rx", 3'h2, 8'ha5);
        rd_chk("flags", 3'h3, 8'h0f);
        chk("edges", n_rise[7:0], 8'h08);
        wr_reg(3'h3, 8'h0c);
        rd_chk("cleared", 3'h3, 8'h0c);
        wr_reg(3'h3, 8'h2c);
        loop <= 1'b0;
        repeat (720) @(negedge clk_i);
        chk("low idle", {7'h00, sck}, 8'h00);
    endtask : t_master
    // Peer clocks a byte, then aborts a slow one halfway
    task automatic t_slave();
        logic [7:0] rx;
        wr_reg(3'h0, {serial_iface_pkg::MODE_SPI_SLV, 5'h02});
        wr_reg(3'h3, 8'h0c);
        wr_reg(3'h2, 8'h96);
        chk("sck in", {7'h00, sck_oe_n}, 8'h01);
        peer.xfer(8'h4b, 8, 0, rx);
        chk("miso", rx, 8'h96);
        wait_done();
        rd_chk("mosi", 3'h2, 8'h4b);
        wr_reg(3'h3, 8'h0c);
        wr_reg(3'h2, 8'h4b);
        peer.xfer(8'hff, 4, 40, rx);
        repeat (4) @(negedge clk_i);
        rd_chk("abort", 3'h0, {serial_iface_pkg::MODE_SPI_SLV, 5'h03});
        rd_chk("kept", 3'h2, 8'h4b);
        rd_chk("abort done", 3'h3, 8'h0d);
    endtask : t_slave
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_modes();
        t_master();
        t_slave();
        stop_test();
    end
    // Hang guard, far beyond the fifteen hundred or so cycles needed
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 32'h0000_4e20) begin
            miscompares++;
            stop_test();
        end
    end
endmodule : tb_serial_iface_spi_i2c_slave
bind serial_iface_spi_i2c_slave serial_iface_asserts u_chk (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .pullup_ctrl_i(pullup_ctrl_i),
    .pullup_en_o(pullup_en_o), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
    .sdi_oe_n_o(sdi_oe_n_o), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
    .sda_oe_n_o(sda_oe_n_o), .scl_oe_n_o(scl_oe_n_o),
    .pins_owned_o(pins_owned_o));
`default_nettype wire
